// *** rtl/config_load_params.svh ***
`ifndef CONFIG_LOAD_PARAMS_SVH
`define CONFIG_LOAD_PARAMS_SVH

// ----------------------------------------
// Clock rate
// ----------------------------------------
`define CLS_CLK_MHZ          250

// ----------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------
`define CLS_POR_FAST_MS      4
`define CLS_POR_STD_MS       100
`define CLS_STATUS_LOW_US    268
`define CLS_INIT_OSC_US      175
`define CLS_UCLK_GAP_NS      40
`define CLS_UCLK_INIT_EDGES  8576
`define CLS_POR_FAST_CYC     (`CLS_POR_FAST_MS * 1000 * `CLS_CLK_MHZ)
`define CLS_POR_STD_CYC      (`CLS_POR_STD_MS * 1000 * `CLS_CLK_MHZ)
`define CLS_STATUS_LOW_CYC   (`CLS_STATUS_LOW_US * `CLS_CLK_MHZ)
`define CLS_INIT_OSC_CYC     (`CLS_INIT_OSC_US * `CLS_CLK_MHZ)
`define CLS_UCLK_GAP_CYC     ((`CLS_UCLK_GAP_NS * `CLS_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// Serial clock half periods, in system cycles
// ----------------------------------------
`define CLS_AS_HALF_0        4'h0_00A
`define CLS_AS_HALF_1        4'h0_005
`define CLS_AS_HALF_2        4'h0_003
`define CLS_AS_HALF_3        4'h0_002

// ----------------------------------------
// Serial read command and field positions
// ----------------------------------------
`define CLS_AS_CMD_READ      32'h0300_0000
`define CLS_AS_CMD_BITS      6'h0_020
`define CLS_SEL_FAST_BIT     3
`define CLS_OPT_INIT_EN_BIT  0
`define CLS_OPT_USER_CLK_BIT 1
`define CLS_BEATS            16

`endif

// *** rtl/config_load_pkg.sv ***
package config_load_pkg;

	typedef enum logic [2:0] {
		MODE_FPP8  = 3'b000,
		MODE_FPP16 = 3'b001,
		MODE_FPP32 = 3'b010,
		MODE_AS1   = 3'b011,
		MODE_AS4   = 3'b100
	} mode_e;

	typedef enum logic [3:0] {
		ST_POR          = 4'b0000,
		ST_STATUS_LOW   = 4'b0001,
		ST_WAIT_RELEASE = 4'b0010,
		ST_CONFIG       = 4'b0011,
		ST_WAIT_COMPL   = 4'b0100,
		ST_INIT_GAP     = 4'b0101,
		ST_INIT_RUN     = 4'b0110,
		ST_USER         = 4'b0111,
		ST_FAULT        = 4'b1000
	} state_e;

endpackage

// *** rtl/level_sync.sv ***
module level_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = meta;
		next_q    = q_o;
		if (en_i) begin
			next_meta = d_i;
			next_q    = meta;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= next_meta;
			q_o  <= next_q;
		end
	end
endmodule

// *** rtl/word_stream_check.sv ***
`include "config_load_params.svh"

module word_stream_check #(
	parameter int unsigned BEATS = `CLS_BEATS,
	parameter int unsigned CW    = $clog2(BEATS + 1)
) (
	input  wire logic        clk_i,
	input  wire logic        clear_i,
	input  wire logic        en_i,
	input  wire logic        valid_i,
	input  wire logic [31:0] data_i,
	output logic             done_o,
	output logic             error_o,
	output logic             opt_valid_o,
	output logic [1:0]       opt_o
);
	logic [CW-1:0] count;
	logic [31:0]   sum;
	logic [CW-1:0] next_count;
	logic [31:0]   next_sum;
	logic          next_done;
	logic          next_error;
	logic          next_opt_valid;
	logic [1:0]    next_opt;

	// First beat carries the option bits, last beat the xor of all before it
	always_comb begin
		next_count     = count;
		next_sum       = sum;
		next_done      = done_o;
		next_error     = error_o;
		next_opt_valid = opt_valid_o;
		next_opt       = opt_o;
		if (valid_i && !done_o) begin
			if (count == '0) begin
				next_opt       = data_i[1:0];
				next_opt_valid = 1'b1;
			end
			if (count == CW'(BEATS - 1)) begin
				next_done  = 1'b1;
				next_error = (sum ^ data_i) != 32'h0000_0000;
			end else begin
				next_sum   = sum ^ data_i;
				next_count = count + CW'(1);
			end
		end
	end

	// Clear may arrive while this clock stands still, hence asynchronous
	always_ff @(posedge clk_i or posedge clear_i) begin
		if (clear_i) begin
			count       <= '0;
			sum         <= 32'h0000_0000;
			done_o      <= 1'b0;
			error_o     <= 1'b0;
			opt_valid_o <= 1'b0;
			opt_o       <= 2'h0;
		end else if (en_i) begin
			count       <= next_count;
			sum         <= next_sum;
			done_o      <= next_done;
			error_o     <= next_error;
			opt_valid_o <= next_opt_valid;
			opt_o       <= next_opt;
		end
	end
endmodule

// *** rtl/config_load_sequencer.sv ***
`include "config_load_params.svh"

module config_load_sequencer #(
	parameter int unsigned POR_FAST_CYC    = `CLS_POR_FAST_CYC,
	parameter int unsigned POR_STD_CYC     = `CLS_POR_STD_CYC,
	parameter int unsigned STATUS_LOW_CYC  = `CLS_STATUS_LOW_CYC,
	parameter int unsigned INIT_OSC_CYC    = `CLS_INIT_OSC_CYC,
	parameter int unsigned UCLK_INIT_EDGES = `CLS_UCLK_INIT_EDGES,
	parameter int unsigned BEATS           = `CLS_BEATS
) (
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire logic        clk_en_i,
	input  wire logic        supplies_ok_i,
	input  wire logic [3:0]  scheme_select_i,
	input  wire logic [1:0]  as_speed_i,
	input  wire logic        multi_device_i,
	input  wire logic        config_request_n_i,
	input  wire logic        config_status_n_i,
	output logic             config_status_n_o,
	output logic             config_status_n_oe_o,
	input  wire logic        config_complete_i,
	output logic             config_complete_o,
	output logic             config_complete_oe_o,
	input  wire logic        config_clock_i,
	output logic             config_clock_o,
	output logic             config_clock_oe_o,
	input  wire logic [31:0] config_data_i,
	input  wire logic        user_init_clock_i,
	output logic             serial_select_n_o,
	output logic             serial_command_out_o,
	input  wire logic [3:0]  serial_config_data_i,
	output logic             init_complete_o,
	output logic             init_complete_oe_o,
	output logic             user_mode_o
);
	import config_load_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [15:0] pin_q;
	logic        supplies_s;
	logic        req_n_s;
	logic        status_in_s;
	logic        complete_in_s;
	logic        uclk_s;
	logic        multi_s;
	logic [1:0]  speed_s;
	logic [3:0]  sel_s;
	logic [3:0]  sdata_s;

	level_sync #(.W(16)) u_pin_sync (
		.clk_i (clock_i),
		.rst_i (sys_rst_i),
		.en_i  (clk_en_i),
		.d_i   ({supplies_ok_i, config_request_n_i, config_status_n_i, config_complete_i,
			user_init_clock_i, multi_device_i, as_speed_i, scheme_select_i,
			serial_config_data_i}),
		.q_o   (pin_q)
	);

	assign {supplies_s, req_n_s, status_in_s, complete_in_s, uclk_s, multi_s, speed_s, sel_s,
		sdata_s} = pin_q;

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	state_e      state;
	state_e      next_state;
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	mode_e       mode;
	mode_e       next_mode;
	logic        uclk_prev;
	logic        check_clear;
	logic        next_check_clear;
	logic        link_clear;
	logic        next_link_clear;
	logic        next_status_drive;
	logic        next_complete_drive;
	logic        next_init_drive;
	logic        next_user;
	logic        as_mode;
	logic        chk_done;
	logic        chk_error;
	logic        chk_opt_valid;
	logic [1:0]  chk_opt;
	logic        as_done;
	logic        as_error;
	logic        as_opt_valid;
	logic [1:0]  as_opt;
	logic [4:0]  lk_res;
	logic [4:0]  lk_res_s;
	logic [31:0] por_lim;
	logic        user_clk_src;

	assign as_mode       = (mode == MODE_AS1) || (mode == MODE_AS4);
	assign chk_done      = as_mode ? as_done : lk_res_s[4];
	assign chk_error     = as_mode ? as_error : lk_res_s[3];
	assign chk_opt_valid = as_mode ? as_opt_valid : lk_res_s[2];
	assign chk_opt       = as_mode ? as_opt : lk_res_s[1:0];
	assign user_clk_src  = chk_opt[`CLS_OPT_USER_CLK_BIT];
	assign por_lim       = sel_s[`CLS_SEL_FAST_BIT] ? POR_FAST_CYC - 1 : POR_STD_CYC - 1;

	always_comb begin
		next_state = state;
		next_cnt   = cnt + 32'h0000_0001;
		next_mode  = mode;
		case (state)
			ST_POR: begin
				next_mode = mode_e'(sel_s[2:0]);
				if (cnt >= por_lim) begin
					next_state = ST_WAIT_RELEASE;
					next_cnt   = 32'h0000_0000;
				end
			end
			ST_STATUS_LOW: begin
				next_mode = mode_e'(sel_s[2:0]);
				if (cnt >= STATUS_LOW_CYC - 1) begin
					next_cnt = cnt;
					if (req_n_s) begin
						next_state = ST_WAIT_RELEASE;
					end
				end
			end
			ST_WAIT_RELEASE: begin
				next_cnt = 32'h0000_0000;
				// An outside agent may still hold status low
				if (status_in_s) begin
					next_state = ST_CONFIG;
				end
			end
			ST_CONFIG: begin
				next_cnt = 32'h0000_0000;
				if (chk_done) begin
					next_state = chk_error ? ST_FAULT : ST_WAIT_COMPL;
				end
			end
			ST_WAIT_COMPL: begin
				next_cnt = 32'h0000_0000;
				// Other chain members may keep the shared line low
				if (complete_in_s) begin
					next_state = user_clk_src ? ST_INIT_GAP : ST_INIT_RUN;
				end
			end
			ST_INIT_GAP: begin
				if (cnt >= `CLS_UCLK_GAP_CYC - 1) begin
					next_state = ST_INIT_RUN;
					next_cnt   = 32'h0000_0000;
				end
			end
			ST_INIT_RUN: begin
				if (user_clk_src) begin
					next_cnt = cnt + {31'h0000_0000, uclk_s && !uclk_prev};
					if (uclk_s && !uclk_prev && cnt == UCLK_INIT_EDGES - 1) begin
						next_state = ST_USER;
					end
				end else if (cnt >= INIT_OSC_CYC - 1) begin
					next_state = ST_USER;
				end
			end
			ST_USER, ST_FAULT: begin
				next_cnt = cnt;
			end
			default: begin
				next_state = ST_POR;
				next_cnt   = 32'h0000_0000;
			end
		endcase
		if (!req_n_s && state != ST_POR) begin
			next_state = ST_STATUS_LOW;
			next_cnt   = 32'h0000_0000;
		end
		if (!supplies_s) begin
			next_state = ST_POR;
			next_cnt   = 32'h0000_0000;
		end
		next_status_drive   = (next_state == ST_POR) || (next_state == ST_STATUS_LOW) ||
			(next_state == ST_FAULT);
		next_complete_drive = (next_state == ST_POR) || (next_state == ST_STATUS_LOW) ||
			(next_state == ST_WAIT_RELEASE) || (next_state == ST_CONFIG) ||
			(next_state == ST_FAULT);
		next_init_drive     = chk_opt_valid && chk_opt[`CLS_OPT_INIT_EN_BIT] &&
			((next_state == ST_CONFIG) || (next_state == ST_WAIT_COMPL) ||
			(next_state == ST_INIT_GAP) || (next_state == ST_INIT_RUN));
		next_user           = next_state == ST_USER;
		next_check_clear    = (next_state == ST_POR) || (next_state == ST_STATUS_LOW);
		next_link_clear     = next_check_clear || (next_mode == MODE_AS1) ||
			(next_mode == MODE_AS4);
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state                <= ST_POR;
			cnt                  <= 32'h0000_0000;
			mode                 <= MODE_FPP8;
			uclk_prev            <= 1'b0;
			check_clear          <= 1'b1;
			link_clear           <= 1'b1;
			config_status_n_oe_o <= 1'b1;
			config_complete_oe_o <= 1'b1;
			init_complete_oe_o   <= 1'b0;
			user_mode_o          <= 1'b0;
		end else if (clk_en_i) begin
			state                <= next_state;
			cnt                  <= next_cnt;
			mode                 <= next_mode;
			uclk_prev            <= uclk_s;
			check_clear          <= next_check_clear;
			link_clear           <= next_link_clear;
			config_status_n_oe_o <= next_status_drive;
			config_complete_oe_o <= next_complete_drive;
			init_complete_oe_o   <= next_init_drive;
			user_mode_o          <= next_user;
		end
	end

	assign config_status_n_o = 1'b0;
	assign config_complete_o = 1'b0;
	assign init_complete_o   = 1'b0;

	// ----------------------------------------
	// Parallel capture on the host clock
	// ----------------------------------------
	logic [31:0] lk_mask;

	// Mode only changes while the capture is held cleared
	always_comb begin
		case (mode)
			MODE_FPP8:  lk_mask = 32'h0000_00FF;
			MODE_FPP16: lk_mask = 32'h0000_FFFF;
			default:    lk_mask = 32'hFFFF_FFFF;
		endcase
	end

	word_stream_check #(.BEATS(BEATS)) u_link_check (
		.clk_i       (config_clock_i),
		.clear_i     (link_clear),
		.en_i        (1'b1),
		.valid_i     (1'b1),
		.data_i      (config_data_i & lk_mask),
		.done_o      (lk_res[4]),
		.error_o     (lk_res[3]),
		.opt_valid_o (lk_res[2]),
		.opt_o       (lk_res[1:0])
	);

	level_sync #(.W(5)) u_res_sync (
		.clk_i (clock_i),
		.rst_i (sys_rst_i),
		.en_i  (clk_en_i),
		.d_i   (lk_res),
		.q_o   (lk_res_s)
	);

	// ----------------------------------------
	// Active serial engine
	// ----------------------------------------
	logic        as_run;
	logic [3:0]  half_cnt;
	logic [3:0]  next_half_cnt;
	logic [3:0]  half_lim;
	logic [1:0]  speed_eff;
	logic        next_sclk;
	logic [5:0]  cmd_cnt;
	logic [5:0]  next_cmd_cnt;
	logic [31:0] cmd_shift;
	logic [31:0] next_cmd_shift;
	logic        next_cmd_out;
	logic [31:0] as_word;
	logic [31:0] next_as_word;
	logic [5:0]  bit_cnt;
	logic [5:0]  next_bit_cnt;
	logic        as_valid;
	logic        next_as_valid;
	logic [5:0]  word_lim;

	assign as_run    = as_mode && (state == ST_CONFIG) && !as_done;
	assign speed_eff = (multi_s && speed_s == 2'h3) ? 2'h2 : speed_s;
	assign word_lim  = (mode == MODE_AS4) ? 6'h0_07 : 6'h1_F;

	always_comb begin
		case (speed_eff)
			2'h0:    half_lim = `CLS_AS_HALF_0;
			2'h1:    half_lim = `CLS_AS_HALF_1;
			2'h2:    half_lim = `CLS_AS_HALF_2;
			default: half_lim = `CLS_AS_HALF_3;
		endcase
	end

	always_comb begin
		next_half_cnt  = 4'h0;
		next_sclk      = 1'b1;
		next_cmd_cnt   = 6'h00;
		next_cmd_shift = `CLS_AS_CMD_READ;
		next_cmd_out   = 1'b0;
		next_as_word   = as_word;
		next_bit_cnt   = 6'h00;
		next_as_valid  = 1'b0;
		if (as_run) begin
			next_half_cnt  = half_cnt + 4'h1;
			next_sclk      = config_clock_o;
			next_cmd_cnt   = cmd_cnt;
			next_cmd_shift = cmd_shift;
			next_cmd_out   = serial_command_out_o;
			next_bit_cnt   = bit_cnt;
			if (half_cnt == half_lim - 4'h1) begin
				next_half_cnt = 4'h0;
				next_sclk     = !config_clock_o;
				if (config_clock_o) begin
					if (cmd_cnt != `CLS_AS_CMD_BITS) begin
						next_cmd_out   = cmd_shift[31];
						next_cmd_shift = {cmd_shift[30:0], 1'b0};
						next_cmd_cnt   = cmd_cnt + 6'h01;
					end else begin
						// Pin path adds two cycles before this falling-edge sample
						next_as_word = (mode == MODE_AS4) ?
							{as_word[27:0], sdata_s} : {as_word[30:0], sdata_s[0]};
						next_bit_cnt  = (bit_cnt == word_lim) ? 6'h00 : bit_cnt + 6'h01;
						next_as_valid = bit_cnt == word_lim;
					end
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			half_cnt             <= 4'h0;
			config_clock_o       <= 1'b1;
			cmd_cnt              <= 6'h00;
			cmd_shift            <= `CLS_AS_CMD_READ;
			serial_command_out_o <= 1'b0;
			as_word              <= 32'h0000_0000;
			bit_cnt              <= 6'h00;
			as_valid             <= 1'b0;
			serial_select_n_o    <= 1'b1;
			config_clock_oe_o    <= 1'b0;
		end else if (clk_en_i) begin
			half_cnt             <= next_half_cnt;
			config_clock_o       <= next_sclk;
			cmd_cnt              <= next_cmd_cnt;
			cmd_shift            <= next_cmd_shift;
			serial_command_out_o <= next_cmd_out;
			as_word              <= next_as_word;
			bit_cnt              <= next_bit_cnt;
			as_valid             <= next_as_valid;
			serial_select_n_o    <= !as_run;
			config_clock_oe_o    <= as_mode && (next_state == ST_CONFIG);
		end
	end

	word_stream_check #(.BEATS(BEATS)) u_serial_check (
		.clk_i       (clock_i),
		.clear_i     (check_clear),
		.en_i        (clk_en_i),
		.valid_i     (as_valid),
		.data_i      (as_word),
		.done_o      (as_done),
		.error_o     (as_error),
		.opt_valid_o (as_opt_valid),
		.opt_o       (as_opt)
	);
endmodule

// *** testbench/config_load_sequencer_sva.sv ***
module config_load_sequencer_sva #(
	parameter int unsigned INIT_OSC_CYC = 25
) (
	input wire logic       clock_i,
	input wire logic       sys_rst_i,
	input wire logic       supplies_ok_i,
	input wire logic [3:0] scheme_select_i,
	input wire logic       config_request_n_i,
	input wire logic       config_status_n_oe_o,
	input wire logic       config_complete_oe_o,
	input wire logic       config_clock_oe_o,
	input wire logic       init_complete_oe_o,
	input wire logic       user_mode_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	// ----------------------------------------
	// Cycles since complete released
	// ----------------------------------------
	int unsigned done_cnt;
	int unsigned next_done_cnt;

	always_comb begin
		next_done_cnt = done_cnt;
		if (config_complete_oe_o) begin
			next_done_cnt = 0;
		end else if (done_cnt < 1000) begin
			next_done_cnt = done_cnt + 1;
		end
	end

	always_ff @(posedge clock_i) begin
		done_cnt <= sys_rst_i ? 0 : next_done_cnt;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_req_held;
		$fell(config_request_n_i) ##1 !config_request_n_i [*5];
	endsequence

	property p_req_complete;
		s_req_held |-> config_complete_oe_o;
	endproperty
	a_req_complete: assert property (p_req_complete) else $error("complete not pulled");

	property p_req_status;
		s_req_held |-> config_status_n_oe_o;
	endproperty
	a_req_status: assert property (p_req_status) else $error("status not pulled");

	property p_status_min;
		$fell(config_request_n_i) |-> ##3 config_status_n_oe_o [*8];
	endproperty
	a_status_min: assert property (p_status_min) else $error("status pulse short");

	property p_status_rel;
		$rose(config_request_n_i) |-> ##[1:60] !config_status_n_oe_o;
	endproperty
	a_status_rel: assert property (p_status_rel) else $error("status not released");

	property p_power;
		!supplies_ok_i [*6] |-> config_status_n_oe_o && !user_mode_o;
	endproperty
	a_power: assert property (p_power) else $error("active without supplies");

	property p_par_clk;
		$stable(scheme_select_i[2:0]) [*6] ##0 (scheme_select_i[2:0] <= 3'h2)
			|-> !config_clock_oe_o;
	endproperty
	a_par_clk: assert property (p_par_clk) else $error("clock driven in parallel");

	property p_user_done;
		user_mode_o |-> !config_complete_oe_o;
	endproperty
	a_user_done: assert property (p_user_done) else $error("user mode, complete low");

	property p_user_init;
		user_mode_o ##1 user_mode_o |-> !init_complete_oe_o;
	endproperty
	a_user_init: assert property (p_user_init) else $error("init still driven");

	property p_osc_time;
		$rose(user_mode_o) |-> done_cnt >= INIT_OSC_CYC;
	endproperty
	a_osc_time: assert property (p_osc_time) else $error("user mode too early");
endmodule

bind config_load_sequencer config_load_sequencer_sva #(
	.INIT_OSC_CYC(INIT_OSC_CYC)
) i_sva (
	.clock_i(clock_i),
	.sys_rst_i(sys_rst_i),
	.supplies_ok_i(supplies_ok_i),
	.scheme_select_i(scheme_select_i),
	.config_request_n_i(config_request_n_i),
	.config_status_n_oe_o(config_status_n_oe_o),
	.config_complete_oe_o(config_complete_oe_o),
	.config_clock_oe_o(config_clock_oe_o),
	.init_complete_oe_o(init_complete_oe_o),
	.user_mode_o(user_mode_o)
);

// *** testbench/config_host_model.sv ***
module config_host_model #(
	parameter int unsigned BEATS = 4
) (
	input  wire logic        uclk_run_i,
	output logic             link_clock_o,
	output logic [31:0]      link_data_o,
	output logic             user_clock_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		link_clock_o = 1'b0;
		link_data_o = 32'h0000_0000;
		user_clock_o = 1'b0;
	end

	// Kept running through init, 32 ns period
	always begin
		#16;
		user_clock_o = uclk_run_i ? ~user_clock_o : 1'b0;
	end

	// 12 ns link period stays under both parallel limits
	task automatic send_frame(input logic [1:0] opts, input logic bad);
		logic [31:0] word;
		logic [31:0] sum;
		sum = 32'h0000_0000;
		#1.3;
		for (int i = 0; i < BEATS; i++) begin
			word = (i == 0) ? {30'h0000_0000, opts} : 32'hA5C3_0000 + 32'(i);
			if (i == BEATS - 1) begin
				word = sum ^ {31'h0000_0000, bad};
			end
			sum = sum ^ word;
			link_data_o = word;
			#6 link_clock_o = 1'b1;
			#6 link_clock_o = 1'b0;
		end
		// Bus stays driven with the last word inverted: no stale word left behind
		link_data_o = ~link_data_o;
	endtask
endmodule

// *** testbench/tb_config_load_sequencer.sv ***
module tb_config_load_sequencer;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int unsigned POR_F = 20;
	localparam int unsigned POR_S = 40;
	localparam int unsigned INIT_OSC = 25;
	localparam int unsigned UEDGES = 8;

	logic        clock_i;
	logic        sys_rst_i;
	logic        supplies_ok;
	logic [3:0]  scheme;
	logic        request_n;
	logic        ext_hold;
	logic        uclk_run;
	logic        clk_en;
	logic        multi_dev;
	logic        status_oe;
	logic        complete_oe;
	logic        clock_o;
	logic        clock_oe;
	logic        init_oe;
	logic        user_mode;
	logic        host_clk;
	logic        uclk;
	logic [31:0] host_data;
	wire logic   status_w;
	wire logic   clk_w;
	int          n_fail = 0;
	int          checked = 0;

	// Open-drain status line with pull-up; clock line muxed between the two drivers
	assign status_w = ~status_oe & ~ext_hold;
	assign clk_w = clock_oe ? clock_o : host_clk;

	config_load_sequencer #(
		.POR_FAST_CYC(POR_F), .POR_STD_CYC(POR_S), .STATUS_LOW_CYC(30),
		.INIT_OSC_CYC(INIT_OSC), .UCLK_INIT_EDGES(UEDGES), .BEATS(4)
	) i_config_load_sequencer (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
		.supplies_ok_i(supplies_ok), .scheme_select_i(scheme), .as_speed_i(2'b00),
		.multi_device_i(multi_dev), .config_request_n_i(request_n),
		.config_status_n_i(status_w), .config_status_n_o(),
		.config_status_n_oe_o(status_oe), .config_complete_i(~complete_oe),
		.config_complete_o(), .config_complete_oe_o(complete_oe),
		.config_clock_i(clk_w), .config_clock_o(clock_o), .config_clock_oe_o(clock_oe),
		.config_data_i(host_data), .user_init_clock_i(uclk), .serial_select_n_o(),
		.serial_command_out_o(), .serial_config_data_i(4'h0),
		.init_complete_o(), .init_complete_oe_o(init_oe), .user_mode_o(user_mode)
	);

	config_host_model #(.BEATS(4)) i_config_host_model (
		.uclk_run_i(uclk_run), .link_clock_o(host_clk),
		.link_data_o(host_data), .user_clock_o(uclk)
	);

	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_por;
		int n;
		n = 0;
		while (status_oe !== 1'b0 && n < 100) begin @(negedge clock_i); n++; end
		check("por_fast", n >= POR_F && n <= POR_F + 8, 1);
		supplies_ok = 1'b0;
		scheme[3] = 1'b0;
		repeat (10) @(negedge clock_i);
		supplies_ok = 1'b1;
		repeat (10) @(negedge clock_i);
		// Frozen cycles must not advance the delay count
		clk_en = 1'b0;
		repeat (10) @(negedge clock_i);
		clk_en = 1'b1;
		n = 0;
		while (status_oe !== 1'b0 && n < 100) begin @(negedge clock_i); n++; end
		check("por_std", n >= POR_S - 10 && n <= POR_S - 2, 1);
	endtask

	task automatic t_request(input logic hold);
		request_n = 1'b0;
		repeat (20) @(negedge clock_i);
		check("status_min", status_oe, 1);
		repeat (130) @(negedge clock_i);
		check("status_low", status_oe, 1);
		check("complete_low", complete_oe, 1);
		repeat (350) @(negedge clock_i);
		ext_hold = hold;
		request_n = 1'b1;
		repeat (60) @(negedge clock_i);
		check("status_rel", status_oe, 0);
		check("status_wire", status_w, !hold);
		ext_hold = 1'b0;
		repeat (500) @(negedge clock_i);
	endtask

	task automatic t_config(input logic [1:0] opts, input logic bad);
		int n;
		uclk_run = opts[1];
		i_config_host_model.send_frame(opts, bad);
		n = 0;
		while (complete_oe !== 1'b0 && n < 40) begin @(negedge clock_i); n++; end
		check("complete_rel", complete_oe, bad);
		if (!bad) begin
			check("init_drive", init_oe, opts[0]);
			n = 0;
			while (user_mode !== 1'b1 && n < 400) begin @(negedge clock_i); n++; end
			if (opts[1]) begin
				check("uclk_time", n >= 10 + (UEDGES - 1) * 8 && n < 400, 1);
			end else begin
				check("osc_time", n >= INIT_OSC && n <= INIT_OSC + 8, 1);
			end
			check("init_free", init_oe, 0);
		end else begin
			repeat (40) @(negedge clock_i);
			check("no_user", user_mode, 0);
		end
		uclk_run = 1'b0;
	endtask

	initial begin
		#60000;
		n_fail++;
		stop_test();
	end

	initial begin
		sys_rst_i = 1'b1;
		supplies_ok = 1'b1;
		scheme = 4'b1010;
		request_n = 1'b1;
		ext_hold = 1'b0;
		uclk_run = 1'b0;
		clk_en = 1'b1;
		multi_dev = 1'b0;
		repeat (5) @(negedge clock_i);
		sys_rst_i = 1'b0;
		t_por();
		t_request(1'b0);
		t_config(2'b01, 1'b0);
		t_request(1'b1);
		t_config(2'b11, 1'b0);
		t_request(1'b0);
		t_config(2'b00, 1'b1);
		stop_test();
	end
endmodule
